/* File: agu_core.sv */
`timescale 1ns/1ps
// Summary of operation
// - registers 26..31 form pointers a, b, c; odd register is high byte
// - register-to-register alu operation finishes in one clock
// - no multiplier; multiply op flagged illegal and has no effect
// - program counter is 10 bits, 1024 words of 16 bits
// - instructions are one or two words; counter advances by length
// - data addresses: 32 registers, 64 i/o, then 128 sram bytes
// - every addressing mode except i/o direct reaches registers, i/o and sram; i/o direct reaches i/o only
// - direct mode takes its 16-bit address from the second word
// - i/o direct takes a 6-bit i/o address from the instruction
// - displacement is the selected pointer a, b or c plus unsigned 6-bit field
// - plain indirect uses the pointer value unchanged
// - pre-decrement lowers pointer first, uses and keeps new value
// - post-increment uses old value, then raises the pointer
// - table read: pointer c bits 10..1 pick word, bit 0 picks byte
// - indirect jump and call load the counter from pointer c
// - relative jump and call: counter plus signed offset plus one
// - two-register ops read both operands and, except compare, write the destination
// - eeprom is a separate byte-wide space
// - immediate ops only target registers 16..31
// - internal sram access takes two clocks
module agu_core
  import agu_pkg::*;
#(
  parameter int SRAM_DEPTH = SRAM_WORDS
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic op_valid_i,
  input wire agu_op_t op_i,
  input wire agu_amode_t amode_i,
  input wire agu_ptr_t ptr_sel_i,
  input wire agu_alu_t alu_op_i,
  input wire logic store_i,
  input wire logic two_word_i,
  input wire logic [4:0] rd_i,
  input wire logic [4:0] rr_i,
  input wire logic [7:0] imm_i,
  input wire logic [5:0] field6_i,
  input wire logic [15:0] word2_i,
  input wire logic [REL_W-1:0] rel_k_i,
  input wire logic [7:0] io_rdata_i,
  input wire logic [15:0] tbl_rdata_i,
  input wire logic [7:0] ee_rdata_i,
  output logic ready_o,
  output logic done_o,
  output logic illegal_o,
  output logic [PC_W-1:0] pc_o,
  output logic [15:0] data_addr_o,
  output logic [2:0] flags_o,
  output logic [IO_AW-1:0] io_addr_o,
  output logic [7:0] io_wdata_o,
  output logic io_we_o,
  output logic io_re_o,
  output logic [PC_W-1:0] tbl_addr_o,
  output logic [EE_AW-1:0] ee_addr_o,
  output logic [7:0] ee_wdata_o,
  output logic ee_we_o,
  output logic ee_re_o
);

  agu_state_t state_q, state_d;
  logic [7:0] rf_q [RF_WORDS];
  logic [PC_W-1:0] pc_q, pc_d, tbl_addr_q, tbl_addr_d;
  logic [15:0] addr_q, addr_d;
  logic [2:0] flags_q, flags_d;
  agu_tgt_t tgt_q, tgt_d;
  logic store_q, store_d, tbl_hi_q, tbl_hi_d;
  logic [4:0] reg_q, reg_d;
  logic done_q, done_d, illegal_q, illegal_d;
  logic [IO_AW-1:0] io_addr_q, io_addr_d;
  logic [7:0] io_wdata_q, io_wdata_d, ee_wdata_q, ee_wdata_d;
  logic io_we_q, io_we_d, io_re_q, io_re_d, ee_we_q, ee_we_d, ee_re_q, ee_re_d;
  logic [EE_AW-1:0] ee_addr_q, ee_addr_d;
  // register-file write ports: a for a byte or pointer low, b for pointer high
  logic wa_en, wb_en, sram_we;
  logic [4:0] wa_addr, wb_addr;
  logic [7:0] wa_data, wb_data, sram_rdata;
  logic [SRAM_AW-1:0] sram_addr;
  function automatic logic [4:0] ptr_lo(input agu_ptr_t sel);
    ptr_lo = (sel == PTR_SEL_A) ? PTR_A_LO : (sel == PTR_SEL_B) ? PTR_B_LO : PTR_C_LO;
  endfunction
  // the odd register of each pair is the high byte
  function automatic logic [15:0] ptr_val(input agu_ptr_t sel);
    ptr_val = {rf_q[ptr_lo(sel) | PTR_HI_BIT], rf_q[ptr_lo(sel)]};
  endfunction
  function automatic agu_tgt_t decode(input logic [15:0] a);
    if (a < DS_IO_BASE) decode = TGT_RF;
    else if (a < DS_SRAM_BASE) decode = TGT_IO;
    else if (a < DS_SRAM_END) decode = TGT_SRAM;
    else decode = TGT_NONE;
  endfunction
  // returns {carry, result}
  function automatic logic [8:0] alu_fn(input agu_alu_t op, input logic [7:0] a,
                                        input logic [7:0] b, input logic cin);
    case (op)
      ALU_ADD: alu_fn = {1'b0, a} + {1'b0, b};
      ALU_ADC: alu_fn = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      ALU_SUB, ALU_CP: alu_fn = {1'b0, a} - {1'b0, b};
      ALU_SBC: alu_fn = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      ALU_AND: alu_fn = {cin, a & b};
      ALU_OR: alu_fn = {cin, a | b};
      ALU_EOR: alu_fn = {cin, a ^ b};
      ALU_MOV: alu_fn = {cin, b};
      ALU_COM: alu_fn = {1'b1, ~a};
      ALU_NEG: alu_fn = 9'h000 - {1'b0, a};
      ALU_INC: alu_fn = {cin, a + 8'h01};
      ALU_DEC: alu_fn = {cin, a - 8'h01};
      ALU_LSR: alu_fn = {a[0], 1'b0, a[7:1]};
      ALU_ROR: alu_fn = {a[0], cin, a[7:1]};
      ALU_SWAP: alu_fn = {cin, a[3:0], a[7:4]};
      default: alu_fn = {cin, a};
    endcase
  endfunction
  // sram address is presented in the accept cycle so the registered read
  // data is ready one clock later, giving the two-clock access
  assign sram_addr = (state_q == ST_IDLE) ? addr_d[SRAM_AW-1:0]
                                          : addr_q[SRAM_AW-1:0];
  assign sram_we = (state_q == ST_ACCESS) && store_q && (tgt_q == TGT_SRAM);
  agu_sram #(.WIDTH(8), .DEPTH(SRAM_DEPTH), .AW(SRAM_AW)) u_sram (
    .mclk_i(mclk_i),
    .we_i(sram_we),
    .addr_i(sram_addr),
    .wdata_i(rf_q[reg_q]),
    .rdata_o(sram_rdata)
  );
  always_comb begin
    logic [15:0] ptr, ea;
    logic [8:0] res;
    logic [4:0] dst;
    logic [7:0] opb, rdv;
    ptr = ptr_val(ptr_sel_i);
    ea = 16'h0000;
    res = 9'h000;
    dst = rd_i;
    opb = rf_q[rr_i];
    rdv = UNMAPPED_RD;
    state_d = state_q;
    pc_d = pc_q;
    addr_d = addr_q;
    flags_d = flags_q;
    tgt_d = tgt_q;
    store_d = store_q;
    reg_d = reg_q;
    done_d = 1'b0;
    illegal_d = 1'b0;
    io_addr_d = io_addr_q;
    io_wdata_d = io_wdata_q;
    io_we_d = 1'b0;
    io_re_d = 1'b0;
    tbl_addr_d = tbl_addr_q;
    tbl_hi_d = tbl_hi_q;
    ee_addr_d = ee_addr_q;
    ee_wdata_d = ee_wdata_q;
    ee_we_d = 1'b0;
    ee_re_d = 1'b0;
    wa_en = 1'b0;
    wa_addr = rd_i;
    wa_data = 8'h00;
    wb_en = 1'b0;
    wb_addr = rd_i;
    wb_data = 8'h00;
    case (state_q)
      ST_IDLE: begin
        if (op_valid_i) begin
          // next sequential word, one or two words on
          pc_d = pc_q + (two_word_i ? PC_TWO : PC_ONE);
          case (op_i)
            OP_ALU, OP_ALU_IMM: begin
              dst = (op_i == OP_ALU_IMM) ? (UPPER_BANK | rd_i) : rd_i;
              opb = (op_i == OP_ALU_IMM) ? imm_i : rf_q[rr_i];
              res = alu_fn(alu_op_i, rf_q[dst], opb, flags_q[FLAG_C]);
              flags_d[FLAG_C] = res[8];
              flags_d[FLAG_Z] = (res[7:0] == 8'h00);
              flags_d[FLAG_N] = res[7];
              wa_en = (alu_op_i != ALU_CP);
              wa_addr = dst;
              wa_data = res[7:0];
              done_d = 1'b1;
            end
            OP_LOAD_IMM: begin
              wa_en = 1'b1;
              wa_addr = UPPER_BANK | rd_i;
              wa_data = imm_i;
              done_d = 1'b1;
            end
            OP_MULTIPLY: begin
              illegal_d = 1'b1;
              done_d = 1'b1;
            end
            OP_DATA: begin
              case (amode_i)
                AM_DIRECT: ea = word2_i;
                AM_IO: ea = DS_IO_BASE + {10'h000, field6_i};
                AM_DISP: ea = ptr + {10'h000, field6_i};
                AM_PREDEC: ea = ptr - 16'h0001;
                default: ea = ptr;
              endcase
              if (amode_i == AM_PREDEC || amode_i == AM_POSTINC) begin
                wa_en = 1'b1;
                wb_en = 1'b1;
                wa_addr = ptr_lo(ptr_sel_i);
                wb_addr = ptr_lo(ptr_sel_i) | PTR_HI_BIT;
                {wb_data, wa_data} = (amode_i == AM_PREDEC) ? ea
                                                            : ptr + 16'h0001;
              end
              addr_d = ea;
              tgt_d = decode(ea);
              store_d = store_i;
              reg_d = rd_i;
              io_addr_d = IO_AW'(ea - DS_IO_BASE);
              io_wdata_d = rf_q[rd_i];
              io_we_d = store_i && (tgt_d == TGT_IO);
              io_re_d = !store_i && (tgt_d == TGT_IO);
              state_d = ST_ACCESS;
            end
            OP_TABLE_READ: begin
              ptr = ptr_val(PTR_SEL_C);
              tbl_addr_d = ptr[PC_W:1];
              tbl_hi_d = ptr[0];
              tgt_d = TGT_TABLE;
              store_d = 1'b0;
              reg_d = rd_i;
              state_d = ST_ACCESS;
            end
            OP_IND_JUMP, OP_IND_CALL: begin
              ptr = ptr_val(PTR_SEL_C);
              pc_d = ptr[PC_W-1:0];
              done_d = 1'b1;
            end
            OP_REL_JUMP, OP_REL_CALL: begin
              // wraps modulo the program space
              pc_d = pc_q + rel_k_i[PC_W-1:0] + PC_ONE;
              done_d = 1'b1;
            end
            OP_EEPROM: begin
              ee_addr_d = imm_i[EE_AW-1:0];
              ee_wdata_d = rf_q[rd_i];
              ee_we_d = store_i;
              ee_re_d = !store_i;
              tgt_d = TGT_EE;
              store_d = store_i;
              reg_d = rd_i;
              state_d = ST_ACCESS;
            end
            default: done_d = 1'b1;
          endcase
        end
      end
      ST_ACCESS: begin
        case (tgt_q)
          TGT_RF: rdv = rf_q[addr_q[4:0]];
          TGT_IO: rdv = io_rdata_i;
          TGT_SRAM: rdv = sram_rdata;
          TGT_TABLE: rdv = tbl_hi_q ? tbl_rdata_i[15:8] : tbl_rdata_i[7:0];
          TGT_EE: rdv = ee_rdata_i;
          default: rdv = UNMAPPED_RD;
        endcase
        // a store above the sram range falls through here and writes nothing
        wa_en = !store_q || (tgt_q == TGT_RF);
        wa_addr = store_q ? addr_q[4:0] : reg_q;
        wa_data = store_q ? rf_q[reg_q] : rdv;
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      pc_q <= PC_RESET;
      addr_q <= 16'h0000;
      flags_q <= 3'h0;
      tgt_q <= TGT_NONE;
      store_q <= 1'b0;
      reg_q <= 5'h00;
      done_q <= 1'b0;
      illegal_q <= 1'b0;
      io_addr_q <= '0;
      io_wdata_q <= 8'h00;
      io_we_q <= 1'b0;
      io_re_q <= 1'b0;
      tbl_addr_q <= '0;
      tbl_hi_q <= 1'b0;
      ee_addr_q <= '0;
      ee_wdata_q <= 8'h00;
      ee_we_q <= 1'b0;
      ee_re_q <= 1'b0;
      for (int i = 0; i < RF_WORDS; i++) begin
        rf_q[i] <= 8'h00;
      end
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      addr_q <= addr_d;
      flags_q <= flags_d;
      tgt_q <= tgt_d;
      store_q <= store_d;
      reg_q <= reg_d;
      done_q <= done_d;
      illegal_q <= illegal_d;
      io_addr_q <= io_addr_d;
      io_wdata_q <= io_wdata_d;
      io_we_q <= io_we_d;
      io_re_q <= io_re_d;
      tbl_addr_q <= tbl_addr_d;
      tbl_hi_q <= tbl_hi_d;
      ee_addr_q <= ee_addr_d;
      ee_wdata_q <= ee_wdata_d;
      ee_we_q <= ee_we_d;
      ee_re_q <= ee_re_d;
      if (wa_en) rf_q[wa_addr] <= wa_data;
      if (wb_en) rf_q[wb_addr] <= wb_data;
    end
  end
  assign ready_o = state_q[0];
  assign done_o = done_q;
  assign illegal_o = illegal_q;
  assign pc_o = pc_q;
  assign data_addr_o = addr_q;
  assign flags_o = flags_q;
  assign io_addr_o = io_addr_q;
  assign io_wdata_o = io_wdata_q;
  assign io_we_o = io_we_q;
  assign io_re_o = io_re_q;
  assign tbl_addr_o = tbl_addr_q;
  assign ee_addr_o = ee_addr_q;
  assign ee_wdata_o = ee_wdata_q;
  assign ee_we_o = ee_we_q;
  assign ee_re_o = ee_re_q;
endmodule // agu_core

/* File: agu_core_monitor.sv */
`timescale 1ns/1ps
module agu_core_monitor
  import agu_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic op_valid_i,
  input wire agu_op_t op_i,
  input wire agu_amode_t amode_i,
  input wire logic two_word_i,
  input wire logic [7:0] imm_i,
  input wire logic [5:0] field6_i,
  input wire logic [15:0] word2_i,
  input wire logic [REL_W-1:0] rel_k_i,
  input wire logic ready_o,
  input wire logic done_o,
  input wire logic illegal_o,
  input wire logic [PC_W-1:0] pc_o,
  input wire logic [15:0] data_addr_o,
  input wire logic [IO_AW-1:0] io_addr_o,
  input wire logic io_we_o,
  input wire logic io_re_o,
  input wire logic [EE_AW-1:0] ee_addr_o,
  input wire logic ee_we_o,
  input wire logic ee_re_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  logic take;
  logic slow;
  logic dat;
  assign take = op_valid_i && ready_o;
  assign slow = op_i inside {OP_DATA, OP_TABLE_READ, OP_EEPROM};
  assign dat = take && op_i == OP_DATA;

  a_single_done: assert property (take && !slow |=> done_o && ready_o)
    else $error("single-cycle op did not finish in one clock");
  a_slow_timing: assert property (take && slow |=> !ready_o && !done_o ##1 ready_o && done_o)
    else $error("memory access did not take two clocks");
  a_mul_illegal: assert property (take && op_i == OP_MULTIPLY |=> illegal_o && done_o)
    else $error("multiply not flagged illegal");
  a_illegal_only_mul: assert property (illegal_o |-> done_o && $past(op_i) == OP_MULTIPLY)
    else $error("illegal flag without multiply");
  a_rel_target: assert property (take && op_i inside {OP_REL_JUMP, OP_REL_CALL}
    |=> pc_o == 10'($past(pc_o) + $past(rel_k_i) + 1))
    else $error("relative target wrong");
  a_pc_step: assert property (take && op_i inside {OP_NOP, OP_ALU}
    |=> pc_o == 10'($past(pc_o) + ($past(two_word_i) ? 2 : 1)))
    else $error("counter step wrong");
  a_pc_hold_busy: assert property (!ready_o |=> $stable(pc_o))
    else $error("counter moved during access");
  a_io_direct: assert property (dat && amode_i == AM_IO
    |=> io_addr_o == $past(field6_i) && (io_we_o || io_re_o))
    else $error("i/o direct access wrong");
  a_direct_addr: assert property (dat && amode_i == AM_DIRECT |=> data_addr_o == $past(word2_i))
    else $error("direct address wrong");
  a_sram_no_io: assert property (dat && amode_i == AM_DIRECT && word2_i >= DS_SRAM_BASE
    |=> !io_we_o && !io_re_o)
    else $error("i/o strobe outside i/o range");
  a_ee_access: assert property (take && op_i == OP_EEPROM
    |=> ee_addr_o == 7'($past(imm_i)) && ee_we_o != ee_re_o)
    else $error("eeprom access wrong");

  c_mul: cover property (take && op_i == OP_MULTIPLY);
  c_predec: cover property (dat && amode_i == AM_PREDEC);
  c_rel: cover property (take && op_i == OP_REL_JUMP);
endmodule // agu_core_monitor

bind agu_core agu_core_monitor i_agu_core_monitor (.*);

/* File: agu_mem_model.sv */
`timescale 1ns/1ps
module agu_mem_model
  import agu_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [IO_AW-1:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic io_we_i,
  input wire logic io_re_i,
  input wire logic [PC_W-1:0] tbl_addr_i,
  input wire logic [EE_AW-1:0] ee_addr_i,
  input wire logic [7:0] ee_wdata_i,
  input wire logic ee_we_i,
  input wire logic ee_re_i,
  output logic [7:0] io_rdata_o,
  output logic [15:0] tbl_rdata_o,
  output logic [7:0] ee_rdata_o
);
  logic [7:0] io_mem [64];
  logic [7:0] ee_mem [128];
  always @(posedge mclk_i) begin
    if (io_we_i) begin
      io_mem[io_addr_i] <= io_wdata_i;
    end
    if (ee_we_i) begin
      ee_mem[ee_addr_i] <= ee_wdata_i;
    end
  end
  // outside a read strobe the lines show the inverse, so a mistimed sample shows
  assign io_rdata_o = io_re_i ? io_mem[io_addr_i] : ~io_mem[io_addr_i];
  // high byte is the inverse of the low, so a wrong byte select shows at once
  assign tbl_rdata_o = {~tbl_addr_i[7:0], tbl_addr_i[7:0]};
  assign ee_rdata_o = ee_re_i ? ee_mem[ee_addr_i] : ~ee_mem[ee_addr_i];
endmodule // agu_mem_model

/* File: agu_pkg.sv */
package agu_pkg;

  // data-space map
  localparam logic [15:0] DS_IO_BASE = 16'h0020;
  localparam logic [15:0] DS_SRAM_BASE = 16'h0060;
  localparam logic [15:0] DS_SRAM_END = 16'h00e0;

  // register file and pointer pair locations, low byte of each pair
  localparam int RF_WORDS = 32;
  localparam logic [4:0] PTR_A_LO = 5'h1a;
  localparam logic [4:0] PTR_B_LO = 5'h1c;
  localparam logic [4:0] PTR_C_LO = 5'h1e;
  localparam logic [4:0] PTR_HI_BIT = 5'h01;
  localparam logic [4:0] UPPER_BANK = 5'h10;

  // program memory
  localparam int PC_W = 10;
  localparam int REL_W = 12;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [PC_W-1:0] PC_ONE = 10'h001;
  localparam logic [PC_W-1:0] PC_TWO = 10'h002;

  // internal sram and eeprom geometry
  localparam int SRAM_WORDS = 128;
  localparam int SRAM_AW = 7;
  localparam int EE_AW = 7;
  localparam int IO_AW = 6;

  // value returned by a read above the implemented range
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // flag positions in flags_o
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_ALU = 4'h1, OP_ALU_IMM = 4'h2, OP_LOAD_IMM = 4'h3,
    OP_MULTIPLY = 4'h4, OP_DATA = 4'h5, OP_TABLE_READ = 4'h6, OP_IND_JUMP = 4'h7,
    OP_IND_CALL = 4'h8, OP_REL_JUMP = 4'h9, OP_REL_CALL = 4'ha, OP_EEPROM = 4'hb
  } agu_op_t;

  typedef enum logic [2:0] {
    AM_DIRECT = 3'h0, AM_IO = 3'h1, AM_DISP = 3'h2, AM_IND = 3'h3,
    AM_PREDEC = 3'h4, AM_POSTINC = 3'h5
  } agu_amode_t;

  typedef enum logic [1:0] {
    PTR_SEL_A = 2'h0, PTR_SEL_B = 2'h1, PTR_SEL_C = 2'h2
  } agu_ptr_t;

  typedef enum logic [3:0] {
    ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
    ALU_AND = 4'h4, ALU_OR = 4'h5, ALU_EOR = 4'h6, ALU_MOV = 4'h7,
    ALU_COM = 4'h8, ALU_NEG = 4'h9, ALU_INC = 4'ha, ALU_DEC = 4'hb,
    ALU_LSR = 4'hc, ALU_ROR = 4'hd, ALU_SWAP = 4'he, ALU_CP = 4'hf
  } agu_alu_t;

  typedef enum logic [2:0] {
    TGT_NONE = 3'h0, TGT_RF = 3'h1, TGT_IO = 3'h2, TGT_SRAM = 3'h3,
    TGT_TABLE = 3'h4, TGT_EE = 3'h5
  } agu_tgt_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACCESS = 2'b10
  } agu_state_t;

endpackage

/* File: agu_sram.sv */
`timescale 1ns/1ps
// single-port byte memory; read data always comes out of a register
module agu_sram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic mclk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rdata_q;

  // no reset on the array: contents are undefined at power-up as in any sram
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_q <= mem_q[addr_i];
  end

  assign rdata_o = rdata_q;

endmodule // agu_sram

/* File: cpu_address_generation_unit_tb.sv */
`timescale 1ns/1ps
module cpu_address_generation_unit_tb;
  import agu_pkg::*;
  logic mclk_i = '0, nrst_i = '0, op_valid_i = '0, store_i = '0, two_word_i = '0;
  agu_op_t op_i = OP_NOP;
  agu_amode_t amode_i = AM_DIRECT;
  agu_ptr_t ptr_sel_i = PTR_SEL_A;
  agu_alu_t alu_op_i = ALU_ADD;
  logic [4:0] rd_i = '0, rr_i = '0;
  logic [7:0] imm_i = '0, io_rdata_i, ee_rdata_i, io_wdata_o, ee_wdata_o;
  logic [5:0] field6_i = '0;
  logic [15:0] word2_i = '0, tbl_rdata_i, data_addr_o;
  logic [REL_W-1:0] rel_k_i = '0;
  logic ready_o, done_o, illegal_o, io_we_o, io_re_o, ee_we_o, ee_re_o, ill;
  logic [PC_W-1:0] pc_o, tbl_addr_o;
  logic [2:0] flags_o;
  logic [IO_AW-1:0] io_addr_o;
  logic [EE_AW-1:0] ee_addr_o;
  int n_errors = 0, comparisons = 0, cyc = 0;

  always #12.5 mclk_i = ~mclk_i;

  agu_core i_agu_core (.*);
  agu_mem_model i_agu_mem_model (.mclk_i(mclk_i), .io_addr_i(io_addr_o),
    .io_wdata_i(io_wdata_o), .io_we_i(io_we_o), .tbl_addr_i(tbl_addr_o),
    .ee_addr_i(ee_addr_o), .ee_wdata_i(ee_wdata_o), .ee_we_i(ee_we_o),
    .io_re_i(io_re_o), .ee_re_i(ee_re_o),
    .io_rdata_o(io_rdata_i), .tbl_rdata_o(tbl_rdata_i), .ee_rdata_o(ee_rdata_i));

  task automatic finish_test;
    if (n_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // about 145 clocks are needed; this leaves ample margin
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // entered just after an edge with ready_o high; returns one edge after done
  task automatic go(input agu_op_t op);
    int n;
    op_i = op;
    op_valid_i = 1'b1;
    @(posedge mclk_i);
    #2 op_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 8) begin
      @(posedge mclk_i);
      #2;
      n++;
    end
    ill = illegal_o;
    check(done_o, 1'b1);
    // let an edge pass so the strobe is never lowered and raised in one step
    @(posedge mclk_i);
    #2;
  endtask

  task automatic ldi(input logic [4:0] r, input logic [7:0] v);
    rd_i = r;
    imm_i = v;
    go(OP_LOAD_IMM);
  endtask

  task automatic ptr(input logic [4:0] lo, input logic [15:0] v);
    ldi(lo, v[7:0]);
    ldi(lo + 5'h01, v[15:8]);
  endtask

  task automatic mem(input agu_amode_t am, input agu_ptr_t p, input logic st,
                     input logic [4:0] r, input logic [15:0] a);
    amode_i = am;
    ptr_sel_i = p;
    store_i = st;
    rd_i = r;
    field6_i = a[5:0];
    word2_i = a;
    go(OP_DATA);
  endtask

  // registers are only visible by storing them to the top i/o location
  task automatic peek(input logic [4:0] r, input logic [7:0] exp);
    mem(AM_IO, PTR_SEL_A, 1'b1, r, 16'h003f);
    check(i_agu_mem_model.io_mem[63], exp);
  endtask

  task automatic t_data;
    ldi(5'h10, 8'h5a);
    ptr(PTR_A_LO, 16'h0025);
    mem(AM_IND, PTR_SEL_A, 1'b1, 5'h10, 16'h0000);
    check(data_addr_o, 16'h0025);
    check(i_agu_mem_model.io_mem[5], 8'h5a);
    mem(AM_IO, PTR_SEL_A, 1'b0, 5'h13, 16'h0005);
    peek(5'h13, 8'h5a);
    ptr(PTR_B_LO, 16'h00ff);
    mem(AM_POSTINC, PTR_SEL_B, 1'b1, 5'h10, 16'h0000);
    check(data_addr_o, 16'h00ff);
    peek(5'h1c, 8'h00);
    peek(5'h1d, 8'h01);
    ldi(5'h11, 8'h77);
    mem(AM_PREDEC, PTR_SEL_B, 1'b0, 5'h11, 16'h0000);
    check(data_addr_o, 16'h00ff);
    peek(5'h11, UNMAPPED_RD);
    peek(5'h1c, 8'hff);
    peek(5'h1d, 8'h00);
    ptr(PTR_C_LO, 16'h0080);
    mem(AM_DISP, PTR_SEL_C, 1'b1, 5'h10, 16'h003f);
    check(data_addr_o, 16'h00bf);
    mem(AM_DIRECT, PTR_SEL_A, 1'b0, 5'h12, 16'h00bf);
    peek(5'h12, 8'h5a);
    peek(5'h1e, 8'h80);
    mem(AM_DIRECT, PTR_SEL_A, 1'b1, 5'h10, 16'h0011);
    peek(5'h11, 8'h5a);
  endtask

  task automatic t_alu;
    ldi(5'h14, 8'h0f);
    ldi(5'h15, 8'h01);
    rd_i = 5'h14;
    rr_i = 5'h15;
    alu_op_i = ALU_ADD;
    go(OP_ALU);
    check(flags_o, 3'h0);
    peek(5'h14, 8'h10);
    rd_i = 5'h14;
    rr_i = 5'h14;
    alu_op_i = ALU_CP;
    go(OP_ALU);
    check(flags_o, 3'(1 << FLAG_Z));
    rd_i = 5'h04;
    imm_i = 8'hf0;
    alu_op_i = ALU_OR;
    go(OP_ALU_IMM);
    peek(5'h14, 8'hf0);
    ldi(5'h05, 8'h33);
    peek(5'h15, 8'h33);
    rd_i = 5'h15;
    rr_i = 5'h14;
    alu_op_i = ALU_SUB;
    go(OP_ALU);
    check(flags_o, 3'(1 << FLAG_C));
    peek(5'h15, 8'h43);
    go(OP_MULTIPLY);
    check(ill, 1'b1);
  endtask

  task automatic t_prog;
    ptr(PTR_C_LO, 16'h0007);
    rd_i = 5'h16;
    go(OP_TABLE_READ);
    check(tbl_addr_o, 10'h003);
    peek(5'h16, 8'hfc);
    ptr(PTR_C_LO, 16'h0006);
    rd_i = 5'h16;
    go(OP_TABLE_READ);
    peek(5'h16, 8'h03);
    ptr(PTR_C_LO, 16'h03f0);
    go(OP_IND_JUMP);
    check(pc_o, 10'h3f0);
    rel_k_i = 12'h020;
    go(OP_REL_JUMP);
    check(pc_o, 10'h011);
    rel_k_i = 12'h800;
    go(OP_REL_CALL);
    check(pc_o, 10'h012);
    two_word_i = 1'b1;
    go(OP_NOP);
    two_word_i = 1'b0;
    check(pc_o, 10'h014);
    go(OP_IND_CALL);
    check(pc_o, 10'h3f0);
  endtask

  task automatic t_ee;
    imm_i = 8'h7f;
    rd_i = 5'h10;
    store_i = 1'b1;
    go(OP_EEPROM);
    check(i_agu_mem_model.ee_mem[127], 8'h5a);
    store_i = 1'b0;
    rd_i = 5'h17;
    go(OP_EEPROM);
    peek(5'h17, 8'h5a);
  endtask

  initial begin
    repeat (5) @(posedge mclk_i);
    #2 nrst_i = 1'b1;
    t_data();
    t_alu();
    t_prog();
    t_ee();
    nrst_i = 1'b0;
    @(posedge mclk_i);
    #2 nrst_i = 1'b1;
    check(pc_o, PC_RESET);
    check(ready_o, 1'b1);
    peek(PTR_C_LO, 8'h00);
    finish_test();
  end
endmodule // cpu_address_generation_unit_tb
